// ---- bench/i2c_master_sequencer_tb.sv ----
// testbench of the i2c master sequencer against a behavioural slave
// assumes open-drain wires with pull-ups resolved here
`timescale 1ns/1ps
`default_nettype none
module i2c_master_sequencer_tb;
  import i2c_seq_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [8:0]  stb = 9'h000;
  logic        wr_valid = 1'b0;
  logic [7:0]  wr_data = 8'h00;
  logic        rx_ready = 1'b0;
  logic        ack_val = 1'b0;
  logic        ack_en = 1'b1;
  logic        tb_pull = 1'b0;
  logic [7:0]  rd_byte = 8'h00;
  logic        scl_oe_n, sda_oe_n, scl_o, sda_o, slv_oe_n, master_ack;
  logic        scl_w, sda_w, rx_valid;
  logic [7:0]  rx_data, last_byte;
  wire  [11:0] st;
  int          failures = 0;
  int          checked = 0;
  logic [7:0]  tbl [2] = '{8'h96, 8'h3C};
  assign scl_w = scl_oe_n | scl_o;
  assign sda_w = (sda_oe_n | sda_o) & slv_oe_n & ~tb_pull;
  initial
    forever #12.5 clk = ~clk;
  i2c_master_sequencer i2c_master_sequencer_inst (
    .i_ref_clk(clk), .i_rst(rst),
    .i_scl_line(scl_w), .o_scl_line(scl_o), .o_scl_line_oe_n(scl_oe_n),
    .i_sda_line(sda_w), .o_sda_line(sda_o), .o_sda_line_oe_n(sda_oe_n),
    .i_baud_reload_value(8'h03), .i_ack_value_to_send(ack_val),
    .i_start_request_set(stb[0]), .i_restart_request_set(stb[1]),
    .i_receive_request_set(stb[2]), .i_ack_sequence_request_set(stb[3]),
    .i_wr_valid(wr_valid), .i_wr_data(wr_data),
    .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .o_rx_data(rx_data),
    .i_serial_event_clr(stb[4]), .i_collision_clr(stb[5]),
    .i_write_collision_clr(stb[6]), .i_receive_overflow_clr(stb[7]),
    .i_start_seen_clr(stb[8]),
    .o_start_request(st[0]), .o_restart_request(st[1]),
    .o_receive_request(st[2]), .o_ack_sequence_request(st[3]),
    .o_buffer_full_flag(st[4]), .o_ack_received_status(st[5]),
    .o_write_collision_flag(st[6]), .o_receive_overflow_flag(st[7]),
    .o_serial_event_flag(st[8]), .o_collision_flag(st[9]),
    .o_start_seen(st[10]), .o_busy(st[11]));
  i2c_slave_model i2c_slave_model_inst (
    .i_scl(scl_w), .i_sda(sda_w), .o_sda_oe_n(slv_oe_n),
    .i_ack_en(ack_en), .i_rd_byte(rd_byte), .o_last_byte(last_byte),
    .o_master_ack(master_ack));
  task test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task pulse(input int k);
    @(negedge clk);
    stb[k] = 1'b1;
    @(negedge clk);
    stb = 9'h000;
    @(negedge clk);
  endtask : pulse
  task wr(input logic [7:0] b);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_data = b;
    @(negedge clk);
    wr_valid = 1'b0;
    @(negedge clk);
  endtask : wr
  // waits for a flag, then clears it
  task wait_hi(input int k);
    int n;
    n = 0;
    while (st[k] !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 3000)
    begin
      failures++;
      $display("MISMATCH t=%0t got 0 exp 1 flag %0h", $time, k);
    end
    pulse(k - 4);
  endtask : wait_hi
  initial
  begin
    #400000;
    failures++;
    test_done;
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk({sda_oe_n, scl_oe_n, st}, 16'h3000);
    tb_pull = 1'b1;
    pulse(0);
    wait_hi(9);
    chk({st[0], st[11], sda_oe_n}, 3'b001);
    tb_pull = 1'b0;
    pulse(0);
    wait_hi(8);
    chk({st[10], st[0], sda_oe_n, scl_oe_n}, 4'h9);
    pulse(8);
    wr(8'h5A);
    chk(st[4], 1'b1);
    wr(8'hFF);
    chk(st[6], 1'b1);
    pulse(6);
    wait_hi(8);
    chk(last_byte, 8'h5A);
    chk({st[5], st[4], scl_oe_n}, 3'b000);
    ack_en = 1'b0;
    wr(8'hC3);
    wait_hi(8);
    chk({last_byte, st[5]}, {8'hC3, 1'b1});
    pulse(1);
    pulse(2);
    chk({st[2], st[1]}, 2'b01);
    ack_en = 1'b1;
    wait_hi(8);
    chk({st[10], st[1], sda_oe_n}, 3'b100);
    rd_byte = tbl[0];
    wr(8'hA1);
    wait_hi(8);
    chk({last_byte, st[5]}, {8'hA1, 1'b0});
    for (int k = 0; k < 2; k++)
    begin
      pulse(2);
      chk(st[2], 1'b1);
      wait_hi(8);
      chk({st[2], st[4], rx_valid}, 3'b011);
      chk(st[7], k[0]);
      rd_byte = tbl[1];
      ack_val = k[0];
      pulse(3);
      wait_hi(8);
      chk({st[3], master_ack}, {1'b0, k[0]});
    end
    for (int k = 0; k < 2; k++)
    begin
      chk(rx_data, tbl[k]);
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
      @(negedge clk);
    end
    chk({st[4], rx_valid}, 2'b00);
    // restart with sda held low by another party must collide
    tb_pull = 1'b1;
    pulse(1);
    wait_hi(9);
    chk({st[1], st[11], sda_oe_n, scl_oe_n}, 4'h3);
    tb_pull = 1'b0;
    test_done;
  end
endmodule : i2c_master_sequencer_tb
`default_nettype wire

// ---- bench/i2c_slave_model.sv ----
// behavioural i2c slave: acks address and written bytes, sends read bytes
// assumes resolved wire levels with pull-ups; pulls sda low when o_sda_oe_n=0
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
  // bus wires
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe_n,
  // control and capture
  input  wire logic       i_ack_en,
  input  wire logic [7:0] i_rd_byte,
  output logic      [7:0] o_last_byte,
  output logic            o_master_ack
);
  logic [3:0] slot;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic       first_byte;
  logic       reading;
  initial
  begin
    slot = 4'hF;
    shift_in = 8'h00;
    shift_out = 8'hFF;
    first_byte = 1'b1;
    reading = 1'b0;
    o_sda_oe_n = 1'b1;
    o_last_byte = 8'h00;
    o_master_ack = 1'b1;
  end
  // start seen: restart the frame and let go of sda
  always @(negedge i_sda)
    if (i_scl === 1'b1)
    begin
      slot = 4'hF;
      first_byte = 1'b1;
      reading = 1'b0;
      o_sda_oe_n = 1'b1;
    end
  always @(posedge i_scl)
  begin
    if (slot < 4'h8)
      shift_in = {shift_in[6:0], i_sda};
    if (slot == 4'h7)
    begin
      o_last_byte = shift_in;
      if (first_byte)
        reading = shift_in[0];
    end
    // a nack from the master ends the read
    if (slot == 4'h8 && reading && !first_byte)
    begin
      o_master_ack = i_sda;
      if (i_sda)
        reading = 1'b0;
    end
  end
  // data changes only while scl is low, msb first
  always @(negedge i_scl)
  begin
    if (slot == 4'h8)
      first_byte = 1'b0;
    slot = (slot >= 4'h8) ? 4'h0 : slot + 4'h1;
    if (slot == 4'h0 && reading)
      shift_out = i_rd_byte;
    if (slot == 4'h8)
      o_sda_oe_n = !((first_byte || !reading) && i_ack_en);
    else if (reading && !first_byte)
      o_sda_oe_n = shift_out[7 - slot];
    else
      o_sda_oe_n = 1'b1;
  end
endmodule : i2c_slave_model
`default_nettype wire

// ---- core/byte_skid_buffer.sv ----
// small fifo of flip-flops with valid/ready on both sides
// assumes the same clock and synchronous reset as its user
`timescale 1ns/1ps
`default_nettype none
module byte_skid_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  // filling side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } fifo_type;

  fifo_type q;
  fifo_type d;
  logic     push;
  logic     pop;

  assign o_in_ready  = (q.cnt != CW'(DEPTH));
  assign o_out_valid = (q.cnt != '0);
  assign o_out_data  = q.mem[q.rd];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr] = i_in_data;
      d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop)
      d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    if (push && !pop)
      d.cnt = q.cnt + 1'b1;
    else if (pop && !push)
      d.cnt = q.cnt - 1'b1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end
endmodule : byte_skid_buffer
`default_nettype wire

// ---- core/i2c_master_sequencer.sv ----
// master sequencer: start, restart, transmit, receive, acknowledge
// assumes open-drain lines resolved outside; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module i2c_master_sequencer (
  // clock and reset
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst,
  // bus pins, open drain
  input  wire logic                          i_scl_line,
  output logic                               o_scl_line,
  output logic                               o_scl_line_oe_n,
  input  wire logic                          i_sda_line,
  output logic                               o_sda_line,
  output logic                               o_sda_line_oe_n,
  // configuration
  input  wire logic [i2c_seq_pkg::BAUD_W-1:0] i_baud_reload_value,
  input  wire logic                          i_ack_value_to_send,
  // request strobes
  input  wire logic                          i_start_request_set,
  input  wire logic                          i_restart_request_set,
  input  wire logic                          i_receive_request_set,
  input  wire logic                          i_ack_sequence_request_set,
  // shift buffer write
  input  wire logic                          i_wr_valid,
  input  wire logic [i2c_seq_pkg::BYTE_W-1:0] i_wr_data,
  // received bytes
  output logic                               o_rx_valid,
  input  wire logic                          i_rx_ready,
  output logic      [i2c_seq_pkg::BYTE_W-1:0] o_rx_data,
  // flag clears
  input  wire logic                          i_serial_event_clr,
  input  wire logic                          i_collision_clr,
  input  wire logic                          i_write_collision_clr,
  input  wire logic                          i_receive_overflow_clr,
  input  wire logic                          i_start_seen_clr,
  // status
  output logic                               o_start_request,
  output logic                               o_restart_request,
  output logic                               o_receive_request,
  output logic                               o_ack_sequence_request,
  output logic                               o_buffer_full_flag,
  output logic                               o_ack_received_status,
  output logic                               o_write_collision_flag,
  output logic                               o_receive_overflow_flag,
  output logic                               o_serial_event_flag,
  output logic                               o_collision_flag,
  output logic                               o_start_seen,
  output logic                               o_busy
);
  import i2c_seq_pkg::*;

  typedef struct packed {
    seq_state_type         state;
    logic [BAUD_W-1:0]     brg;
    logic [BITCNT_W-1:0]   bitcnt;
    logic [BYTE_W-1:0]     shreg;
    logic                  armed;
    logic                  scl_drv;
    logic                  sda_drv;
    logic                  start_req;
    logic                  restart_req;
    logic                  rx_req;
    logic                  ack_req;
    logic                  tx_full;
    logic                  ack_stat;
    logic                  write_collision_flag;
    logic                  ovf;
    logic                  event_f;
    logic                  coll;
    logic                  start_seen;
    logic                  scl_m;
    logic                  scl_s;
    logic                  sda_m;
    logic                  sda_s;
  } seq_type;

  seq_type q;
  seq_type d;
  logic    expire;
  logic    idle;
  logic    lines_high;
  logic    push;
  logic    push_ready;
  logic    rx_full;

  assign expire     = (q.brg == '0);
  assign idle       = (q.state == S_IDLE);
  assign lines_high = q.scl_s && q.sda_s;
  assign push       = (q.state == S_RX_DONE);

  byte_skid_buffer #(
    .WIDTH (BYTE_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_buf (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push),
    .o_in_ready  (push_ready),
    .i_in_data   (q.shreg),
    .o_out_valid (rx_full),
    .i_out_ready (i_rx_ready),
    .o_out_data  (o_rx_data)
  );

  always_comb
  begin
    d = q;
    d.scl_m = i_scl_line;
    d.scl_s = q.scl_m;
    d.sda_m = i_sda_line;
    d.sda_s = q.sda_m;
    d.brg   = expire ? '0 : q.brg - 1'b1;
    // clears first so a same-cycle set wins
    if (i_serial_event_clr)     d.event_f    = 1'b0;
    if (i_collision_clr)        d.coll       = 1'b0;
    if (i_write_collision_clr)  d.write_collision_flag       = 1'b0;
    if (i_receive_overflow_clr) d.ovf        = 1'b0;
    if (i_start_seen_clr)       d.start_seen = 1'b0;
    // requests latch only while idle
    if (idle && !q.start_req && !q.restart_req &&
        !q.rx_req && !q.ack_req)
    begin
      d.start_req = i_start_request_set;
      d.restart_req = i_restart_request_set;
      d.rx_req  = i_receive_request_set;
      d.ack_req = i_ack_sequence_request_set;
    end
    if (i_wr_valid && (!idle || q.write_collision_flag || q.start_req ||
        q.restart_req || q.rx_req || q.ack_req))
      d.write_collision_flag = 1'b1;
    case (q.state)
      S_IDLE:
      begin
        if (q.start_req)
        begin
          if (lines_high)
          begin
            d.brg   = i_baud_reload_value;
            d.state = S_ST_WAIT;
          end
          else
          begin
            d.coll      = 1'b1;
            d.start_req = 1'b0;
          end
        end
        else if (q.restart_req)
        begin
          d.scl_drv = 1'b1;
          d.state   = S_RS_LOW;
        end
        else if (q.rx_req)
        begin
          d.scl_drv = 1'b1;
          d.sda_drv = 1'b0;
          d.bitcnt  = '0;
          d.brg     = i_baud_reload_value;
          d.state   = S_RX_LOW;
        end
        else if (q.ack_req)
        begin
          d.scl_drv = 1'b1;
          d.sda_drv = !i_ack_value_to_send;
          d.brg     = i_baud_reload_value;
          d.state   = S_ACK_LOW;
        end
        else if (i_wr_valid && !q.write_collision_flag)
        begin
          d.tx_full = 1'b1;
          d.shreg   = i_wr_data;
          d.bitcnt  = '0;
          d.scl_drv = 1'b1;
          // first bit goes out once scl is already low
          d.armed   = 1'b1;
          d.brg     = i_baud_reload_value;
          d.state   = S_TX_LOW;
        end
      end
      S_ST_WAIT:
      begin
        if (!q.scl_s || (expire && !q.sda_s))
        begin
          d.coll      = 1'b1;
          d.start_req = 1'b0;
          d.state     = S_IDLE;
        end
        else if (expire)
        begin
          d.sda_drv    = 1'b1;
          d.start_seen = 1'b1;
          d.brg        = i_baud_reload_value;
          d.state      = S_ST_HOLD;
        end
      end
      S_ST_HOLD:
      begin
        if (expire)
        begin
          d.start_req = 1'b0;
          d.event_f   = 1'b1;
          d.state     = S_IDLE;
        end
      end
      S_RS_LOW:
      begin
        if (!q.scl_s)
        begin
          d.sda_drv = 1'b0;
          d.brg     = i_baud_reload_value;
          d.state   = S_RS_SDA;
        end
      end
      S_RS_SDA:
      begin
        if (expire)
        begin
          if (q.sda_s)
          begin
            d.scl_drv = 1'b0;
            d.state   = S_RS_RISE;
          end
          else
          begin
            d.coll        = 1'b1;
            d.restart_req = 1'b0;
            d.scl_drv     = 1'b0;
            d.state       = S_IDLE;
          end
        end
      end
      S_RS_RISE:
      begin
        if (q.scl_s)
        begin
          if (!q.sda_s)
          begin
            d.coll        = 1'b1;
            d.restart_req = 1'b0;
            d.state       = S_IDLE;
          end
          else
          begin
            d.brg   = i_baud_reload_value;
            d.state = S_RS_HIGH;
          end
        end
      end
      S_RS_HIGH:
      begin
        if (!lines_high)
        begin
          d.coll        = 1'b1;
          d.restart_req = 1'b0;
          d.state       = S_IDLE;
        end
        else if (expire)
        begin
          d.sda_drv    = 1'b1;
          d.start_seen = 1'b1;
          d.brg        = i_baud_reload_value;
          d.state      = S_RS_SDAL;
        end
      end
      S_RS_SDAL:
      begin
        if (expire)
        begin
          d.scl_drv     = 1'b1;
          d.restart_req = 1'b0;
          d.event_f     = 1'b1;
          d.state       = S_IDLE;
        end
      end
      S_TX_LOW:
      begin
        // sda moves a cycle after scl falls, never with it
        if (q.armed)
        begin
          d.armed = 1'b0;
          if (q.bitcnt == ACK_BIT)
          begin
            d.sda_drv = 1'b0;
          end
          else
          begin
            d.sda_drv = !q.shreg[BYTE_W-1];
            d.shreg   = {q.shreg[BYTE_W-2:0], 1'b0};
          end
        end
        if (expire)
        begin
          d.scl_drv = 1'b0;
          d.armed   = 1'b0;
          d.state   = S_TX_HIGH;
        end
      end
      S_TX_HIGH:
      begin
        if (!q.armed)
        begin
          if (q.scl_s)
          begin
            d.armed = 1'b1;
            d.brg   = i_baud_reload_value;
            if (q.bitcnt == ACK_BIT)
              d.ack_stat = q.sda_s;
          end
        end
        else if (expire)
        begin
          d.scl_drv = 1'b1;
          if (q.bitcnt == ACK_BIT)
          begin
            d.event_f = 1'b1;
            d.state   = S_IDLE;
          end
          else
          begin
            d.bitcnt = q.bitcnt + 1'b1;
            d.brg    = i_baud_reload_value;
            d.armed  = 1'b1;
            d.state  = S_TX_LOW;
            if (q.bitcnt == LAST_BIT)
            begin
              d.tx_full = 1'b0;
            end
          end
        end
      end
      S_RX_LOW:
      begin
        if (expire)
        begin
          d.scl_drv = 1'b0;
          d.armed   = 1'b0;
          d.state   = S_RX_HIGH;
        end
      end
      S_RX_HIGH:
      begin
        if (!q.armed)
        begin
          if (q.scl_s)
          begin
            d.armed = 1'b1;
            d.brg   = i_baud_reload_value;
            d.shreg = {q.shreg[BYTE_W-2:0], q.sda_s};
          end
        end
        else if (expire)
        begin
          d.scl_drv = 1'b1;
          d.brg     = i_baud_reload_value;
          d.bitcnt  = q.bitcnt + 1'b1;
          d.state   = (q.bitcnt == LAST_BIT) ? S_RX_DONE : S_RX_LOW;
        end
      end
      S_RX_DONE:
      begin
        if (push_ready)
        begin
          if (rx_full)
            d.ovf = 1'b1;
          d.rx_req  = 1'b0;
          d.event_f = 1'b1;
          d.state   = S_IDLE;
        end
      end
      S_ACK_LOW:
      begin
        if (expire)
        begin
          d.scl_drv = 1'b0;
          d.armed   = 1'b0;
          d.state   = S_ACK_HIGH;
        end
      end
      S_ACK_HIGH:
      begin
        if (!q.armed)
        begin
          if (q.scl_s)
          begin
            d.armed = 1'b1;
            d.brg   = i_baud_reload_value;
          end
        end
        else if (expire)
        begin
          d.scl_drv = 1'b1;
          d.ack_req = 1'b0;
          d.event_f = 1'b1;
          d.state   = S_IDLE;
        end
      end
      default:
      begin
        d.state = S_IDLE;
      end
    endcase
    // aborts that newly set the collision flag let both lines go
    if (d.coll && !q.coll)
    begin
      d.scl_drv = 1'b0;
      d.sda_drv = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      q       <= '0;
      q.state <= S_IDLE;
    end
    else
      q <= d;
  end

  assign o_scl_line              = 1'b0;
  assign o_sda_line              = 1'b0;
  assign o_scl_line_oe_n         = !q.scl_drv;
  assign o_sda_line_oe_n         = !q.sda_drv;
  assign o_rx_valid              = rx_full;
  assign o_start_request         = q.start_req;
  assign o_restart_request       = q.restart_req;
  assign o_receive_request       = q.rx_req;
  assign o_ack_sequence_request  = q.ack_req;
  assign o_buffer_full_flag      = q.tx_full || rx_full;
  assign o_ack_received_status   = q.ack_stat;
  assign o_write_collision_flag  = q.write_collision_flag;
  assign o_receive_overflow_flag = q.ovf;
  assign o_serial_event_flag     = q.event_f;
  assign o_collision_flag        = q.coll;
  assign o_start_seen            = q.start_seen;
  assign o_busy                  = !idle;

  start_gate_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    idle && q.start_req && lines_high
    |=> q.state == S_ST_WAIT && q.brg == $past(i_baud_reload_value))
    else $error("start did not load baud");
  start_drive_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    q.state == S_ST_WAIT && expire && lines_high
    |=> q.sda_drv && q.start_seen && !o_sda_line_oe_n)
    else $error("start did not drive sda");
  start_done_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    q.state == S_ST_HOLD && expire
    |=> !q.start_req && q.sda_drv && idle && q.event_f)
    else $error("start did not complete");
  start_coll_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    idle && q.start_req && !lines_high |=> q.coll && !q.start_req)
    else $error("start collision missed");
  restart_ign_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    !idle && !q.restart_req |=> !q.restart_req)
    else $error("restart taken while busy");
  restart_coll_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    q.state == S_RS_SDA && expire && !q.sda_s
    |=> q.coll && idle && !q.restart_req && !q.scl_drv && !q.sda_drv)
    else $error("restart collision missed");
  write_collision_flag_set_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_wr_valid && !idle |=> q.write_collision_flag && $stable(q.tx_full))
    else $error("busy write not refused");
  tx_free_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    q.state == S_TX_HIGH && q.armed && expire && q.bitcnt == LAST_BIT
    |=> !q.tx_full && q.scl_drv ##1 !q.sda_drv)
    else $error("eighth fall did not free sda");
  ack_cap_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    q.state == S_TX_HIGH && !q.armed && q.scl_s && q.bitcnt == ACK_BIT
    |=> q.ack_stat == $past(q.sda_s))
    else $error("acknowledge not captured");
  rx_fill_a: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    push && push_ready |=> !q.rx_req && q.event_f && rx_full && idle)
    else $error("received byte not stored");
endmodule : i2c_master_sequencer
`default_nettype wire

// ---- core/i2c_seq_pkg.sv ----
// constants and state codes of the i2c master sequencer
// assumes a single 40 MHz clock and a synchronous active-high reset
//
// How it works
// - start request with idle lines loads baud
// - expiry with lines high drives sda low
// - one more period, clear request, hold sda
// - low lines or early scl fall collide
// - restart request taken only when idle
// - restart: scl low, release sda, release scl
// - restart: both high, sda low, scl low
// - start seen early, event after expiry
// - restart collides on sda low or scl fall
// - buffer write when idle, write collision clear, starts transmit
// - scl low one period, high one period
// - address sent as seven bits plus direction
// - eighth fall clears full, releases sda
// - ninth clock captures acknowledge into status
// - after ninth clock: event, scl held low
// - busy write discarded, write collision set
// - receive request taken only when idle
// - receive eight bits, load buffer, flag
// - reading the last buffered received byte clears full flag
// - byte completed while full sets overflow
// - ack sequence: drive, release, low, idle
package i2c_seq_pkg;
  localparam int BAUD_W    = 8;
  localparam int BYTE_W    = 8;
  localparam int BITCNT_W  = 4;
  localparam int RX_DEPTH  = 2;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT  = 4'h8;

  typedef enum logic [14:0] {
    S_IDLE     = 15'h0001,
    S_ST_WAIT  = 15'h0002,
    S_ST_HOLD  = 15'h0004,
    S_RS_LOW   = 15'h0008,
    S_RS_SDA   = 15'h0010,
    S_RS_RISE  = 15'h0020,
    S_RS_HIGH  = 15'h0040,
    S_RS_SDAL  = 15'h0080,
    S_TX_LOW   = 15'h0100,
    S_TX_HIGH  = 15'h0200,
    S_RX_LOW   = 15'h0400,
    S_RX_HIGH  = 15'h0800,
    S_RX_DONE  = 15'h1000,
    S_ACK_LOW  = 15'h2000,
    S_ACK_HIGH = 15'h4000
  } seq_state_type;
endpackage : i2c_seq_pkg
